// ---- design/ddc_pkg.sv ----
package ddc_pkg;
  localparam int ADC_W = 14;
  localparam int DATA_W = 20;
  localparam int NCO_W = 32;
  localparam int LUT_W = 12;
  localparam int ACC_W = 25;
  localparam int DEC_W = 3;
  localparam int SYNC_CNT_W = 6;
  localparam int ADDR_W = 8;
  localparam int MIX_LSB = 5;
  localparam int PAD_W = DATA_W - ADC_W;
  localparam logic [DEC_W-1:0] DEC_MIN = 3'h1;
  localparam logic [DEC_W-1:0] DEC_MAX = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_NCO_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_NCO_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESTART = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ACT_A = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ACT_B = 8'h18;
  localparam int CTRL_EN = 0;
  localparam int CTRL_REAL = 1;
  localparam int CTRL_GAIN6 = 2;
  localparam int CTRL_GAIN3 = 3;
  localparam int CTRL_FS4 = 4;
  localparam int CTRL_INV_A = 5;
  localparam int CTRL_DUAL = 6;
  localparam int CTRL_INV_B = 7;
  localparam int CTRL_DEC_LSB = 8;
  localparam int CTRL_PIN_EN = 11;
  localparam int RESTART_BIT = 0;
  localparam int ST_PEND_A = 0;
  localparam int ST_PEND_B = 1;
  localparam int ST_SYNC_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] NCO_RST = 32'h0000_0000;
endpackage : ddc_pkg

// ---- design/ddc_iq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ddc_iq_if;
  logic valid;
  logic signed [ddc_pkg::DATA_W-1:0] i;
  logic signed [ddc_pkg::DATA_W-1:0] q;
  modport src (output valid, output i, output q);
  modport dst (input valid, input i, input q);
endinterface : ddc_iq_if
`default_nettype wire

// ---- design/ddc_nco.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddc_nco (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic [ddc_pkg::NCO_W-1:0] freq_pending,
  // oscillator
  output logic [ddc_pkg::NCO_W-1:0] freq_active,
  output logic signed [ddc_pkg::LUT_W-1:0] cos_out,
  output logic signed [ddc_pkg::LUT_W-1:0] sin_out
);
  typedef struct packed {
    logic [ddc_pkg::NCO_W-1:0] phase;
    logic [ddc_pkg::NCO_W-1:0] freq;
    logic signed [ddc_pkg::LUT_W-1:0] c;
    logic signed [ddc_pkg::LUT_W-1:0] s;
  } ddc_nco_st_t;

  ddc_nco_st_t st_reg;
  ddc_nco_st_t st_next;

  // quarter-wave table, half-step offset keeps the wave free of a dc term
  function automatic logic signed [ddc_pkg::LUT_W-1:0] sine(input logic [5:0] p);
    logic [3:0] idx;
    logic [ddc_pkg::LUT_W-1:0] m;
    idx = p[4] ? ~p[3:0] : p[3:0];
    unique case (idx)
      4'h0: m = 12'h064;
      4'h1: m = 12'h12C;
      4'h2: m = 12'h1F1;
      4'h3: m = 12'h2B2;
      4'h4: m = 12'h36B;
      4'h5: m = 12'h41C;
      4'h6: m = 12'h4C3;
      4'h7: m = 12'h55F;
      4'h8: m = 12'h5ED;
      4'h9: m = 12'h66C;
      4'hA: m = 12'h6DC;
      4'hB: m = 12'h73A;
      4'hC: m = 12'h787;
      4'hD: m = 12'h7C2;
      4'hE: m = 12'h7E9;
      4'hF: m = 12'h7FD;
    endcase
    return p[5] ? -$signed(m) : $signed(m);
  endfunction : sine

  always_comb begin
    st_next = st_reg;
    if (restart) begin
      st_next.phase = '0;
      st_next.freq = freq_pending;
    end else begin
      // two's complement wrap gives the signed range of rotation
      st_next.phase = st_reg.phase + st_reg.freq;
    end
    st_next.c = sine(st_reg.phase[31:26] + 6'h10);
    st_next.s = sine(st_reg.phase[31:26]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign freq_active = st_reg.freq;
  assign cos_out = st_reg.c;
  assign sin_out = st_reg.s;
endmodule : ddc_nco
`default_nettype wire

// ---- design/ddc_decim.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddc_decim (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic [ddc_pkg::DEC_W-1:0] log2n,
  // one sample per clock
  input wire logic signed [ddc_pkg::DATA_W-1:0] in_i,
  input wire logic signed [ddc_pkg::DATA_W-1:0] in_q,
  // decimated stream
  ddc_iq_if.src out
);
  typedef struct packed {
    logic [4:0] cnt;
    logic signed [ddc_pkg::ACC_W-1:0] acc_i;
    logic signed [ddc_pkg::ACC_W-1:0] acc_q;
    logic valid;
    logic signed [ddc_pkg::DATA_W-1:0] i;
    logic signed [ddc_pkg::DATA_W-1:0] q;
  } ddc_dec_st_t;

  ddc_dec_st_t st_reg;
  ddc_dec_st_t st_next;
  logic signed [ddc_pkg::ACC_W-1:0] sum_i;
  logic signed [ddc_pkg::ACC_W-1:0] sum_q;
  logic [4:0] last;

  // boxcar average: cheap, but far from the full stop-band rejection
  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    sum_i = st_reg.acc_i + ddc_pkg::ACC_W'(in_i);
    sum_q = st_reg.acc_q + ddc_pkg::ACC_W'(in_q);
    last = 5'((6'h01 << log2n) - 6'h01);
    if (clear) begin
      st_next.cnt = '0;
      st_next.acc_i = '0;
      st_next.acc_q = '0;
    end else if (st_reg.cnt == last) begin
      st_next.cnt = '0;
      st_next.acc_i = '0;
      st_next.acc_q = '0;
      st_next.valid = 1'b1;
      st_next.i = ddc_pkg::DATA_W'(sum_i >>> log2n);
      st_next.q = ddc_pkg::DATA_W'(sum_q >>> log2n);
    end else begin
      st_next.cnt = st_reg.cnt + 5'h01;
      st_next.acc_i = sum_i;
      st_next.acc_q = sum_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out.valid = st_reg.valid;
  assign out.i = st_reg.i;
  assign out.q = st_reg.q;
endmodule : ddc_decim
`default_nettype wire

// ---- design/ddc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter samples, one per clock
  input wire logic [ddc_pkg::ADC_W-1:0] adc_sample,
  input wire logic powerdown_or_align_pin,
  // first lane pair
  output logic out_valid,
  output logic [ddc_pkg::DATA_W-1:0] out_i,
  output logic [ddc_pkg::DATA_W-1:0] out_q,
  // second lane pair
  output logic second_lane_pair_valid,
  output logic [ddc_pkg::DATA_W-1:0] second_lane_pair_i,
  output logic [ddc_pkg::DATA_W-1:0] second_lane_pair_q
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] nco_a;
    logic [31:0] nco_b;
    logic restart_bit;
    logic pend_a;
    logic pend_b;
    logic pin_s1;
    logic pin_s2;
    logic pin_last;
    logic sync_pulse;
    logic [ddc_pkg::SYNC_CNT_W-1:0] sync_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fs4_odd;
    logic fs4_pend;
    logic [ddc_pkg::DATA_W-1:0] fs4_hold;
    logic o_valid;
    logic [ddc_pkg::DATA_W-1:0] o_i;
    logic [ddc_pkg::DATA_W-1:0] o_q;
    logic b_valid;
    logic [ddc_pkg::DATA_W-1:0] b_i;
    logic [ddc_pkg::DATA_W-1:0] b_q;
  } ddc_top_st_t;

  ddc_top_st_t st_reg;
  ddc_top_st_t st_next;

  ddc_iq_if dec_a ();
  ddc_iq_if dec_b ();

  logic [31:0] act_a;
  logic [31:0] act_b;
  logic signed [ddc_pkg::LUT_W-1:0] cos_a;
  logic signed [ddc_pkg::LUT_W-1:0] sin_a;
  logic signed [ddc_pkg::LUT_W-1:0] cos_b;
  logic signed [ddc_pkg::LUT_W-1:0] sin_b;
  logic signed [ddc_pkg::DATA_W-1:0] mix_ai;
  logic signed [ddc_pkg::DATA_W-1:0] mix_aq;
  logic signed [ddc_pkg::DATA_W-1:0] mix_bi;
  logic signed [ddc_pkg::DATA_W-1:0] mix_bq;
  logic signed [ddc_pkg::DATA_W-1:0] raw;
  logic [ddc_pkg::DEC_W-1:0] log2n;
  logic en;
  logic real_mode;
  logic dual;
  logic dec_clear;

  // product of a sample and one oscillator component, kept at 20 bits
  function automatic logic signed [ddc_pkg::DATA_W-1:0] mix(
    input logic signed [ddc_pkg::ADC_W-1:0] x,
    input logic signed [ddc_pkg::LUT_W-1:0] lo,
    input logic neg
  );
    logic signed [ddc_pkg::ADC_W+ddc_pkg::LUT_W-1:0] p;
    p = x * lo;
    if (neg) begin
      p = -p;
    end
    return p[ddc_pkg::MIX_LSB +: ddc_pkg::DATA_W];
  endfunction : mix

  function automatic logic [ddc_pkg::DATA_W-1:0] sat(input logic signed [22:0] v);
    if (v > 23'sh03FFFF) begin
      return 20'h7FFFF;
    end else if (v < -23'sh040000) begin
      return 20'h80000;
    end else begin
      return v[ddc_pkg::DATA_W-1:0];
    end
  endfunction : sat

  // 3 dB is approximated by 1 + 1/4 + 1/8 + 1/32
  function automatic logic [ddc_pkg::DATA_W-1:0] gain(
    input logic signed [ddc_pkg::DATA_W-1:0] v,
    input logic g6,
    input logic g3,
    input logic neg
  );
    logic signed [22:0] w;
    w = 23'(v);
    if (g6) begin
      w = w <<< 1;
    end else if (g3) begin
      w = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
    end
    if (neg) begin
      w = -w;
    end
    return sat(w);
  endfunction : gain

  function automatic logic [ddc_pkg::DEC_W-1:0] dec_sel(input logic [ddc_pkg::DEC_W-1:0] v);
    if (v < ddc_pkg::DEC_MIN) begin
      return ddc_pkg::DEC_MIN;
    end else if (v > ddc_pkg::DEC_MAX) begin
      return ddc_pkg::DEC_MAX;
    end else begin
      return v;
    end
  endfunction : dec_sel

  assign en = st_reg.ctrl[ddc_pkg::CTRL_EN];
  assign real_mode = st_reg.ctrl[ddc_pkg::CTRL_REAL];
  assign dual = st_reg.ctrl[ddc_pkg::CTRL_DUAL];
  assign log2n = dec_sel(st_reg.ctrl[ddc_pkg::CTRL_DEC_LSB +: ddc_pkg::DEC_W]);
  assign dec_clear = st_reg.sync_pulse | ~en;
  assign raw = {adc_sample, ddc_pkg::PAD_W'(0)};

  // e^{+jwn} gives Q = x*sin; inverting the phase negates Q
  always_comb begin
    if (real_mode) begin
      mix_ai = raw;
      mix_aq = '0;
      mix_bi = raw;
      mix_bq = '0;
    end else begin
      mix_ai = mix(adc_sample, cos_a, 1'b0);
      mix_aq = mix(adc_sample, sin_a, st_reg.ctrl[ddc_pkg::CTRL_INV_A]);
      mix_bi = mix(adc_sample, cos_b, 1'b0);
      mix_bq = mix(adc_sample, sin_b, st_reg.ctrl[ddc_pkg::CTRL_INV_B]);
    end
  end

  ddc_nco u_nco_a (
    .pclk(pclk),
    .presetn(presetn),
    .restart(st_reg.sync_pulse),
    .freq_pending(st_reg.nco_a),
    .freq_active(act_a),
    .cos_out(cos_a),
    .sin_out(sin_a)
  );

  ddc_nco u_nco_b (
    .pclk(pclk),
    .presetn(presetn),
    .restart(st_reg.sync_pulse),
    .freq_pending(st_reg.nco_b),
    .freq_active(act_b),
    .cos_out(cos_b),
    .sin_out(sin_b)
  );

  ddc_decim u_dec_a (
    .pclk(pclk),
    .presetn(presetn),
    .clear(dec_clear),
    .log2n(log2n),
    .in_i(mix_ai),
    .in_q(mix_aq),
    .out(dec_a.src)
  );

  ddc_decim u_dec_b (
    .pclk(pclk),
    .presetn(presetn),
    .clear(dec_clear | ~dual),
    .log2n(log2n),
    .in_i(mix_bi),
    .in_q(mix_bq),
    .out(dec_b.src)
  );

  always_comb begin
    logic setup;
    logic wr;
    logic hit;
    logic pin_rise;
    logic g6;
    logic g3;
    setup = psel & ~penable & ~st_reg.pready;
    wr = psel & penable & st_reg.pready & pwrite & ~st_reg.pslverr;
    hit = (paddr == ddc_pkg::OFF_CTRL) || (paddr == ddc_pkg::OFF_NCO_A)
      || (paddr == ddc_pkg::OFF_NCO_B) || (paddr == ddc_pkg::OFF_RESTART)
      || (paddr == ddc_pkg::OFF_STATUS) || (paddr == ddc_pkg::OFF_ACT_A)
      || (paddr == ddc_pkg::OFF_ACT_B);
    g6 = st_reg.ctrl[ddc_pkg::CTRL_GAIN6];
    g3 = st_reg.ctrl[ddc_pkg::CTRL_GAIN3];
    pin_rise = st_reg.ctrl[ddc_pkg::CTRL_PIN_EN] & st_reg.pin_s2 & ~st_reg.pin_last;
    st_next = st_reg;

    // pin passes two flops; only the second one feeds the edge detector
    st_next.pin_s1 = powerdown_or_align_pin;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_last = st_reg.pin_s2;

    // apb: answer in the first access cycle, registered read data
    st_next.pready = setup;
    st_next.pslverr = setup & ~hit;
    if (setup) begin
      unique case (paddr)
        ddc_pkg::OFF_CTRL: st_next.prdata = st_reg.ctrl;
        ddc_pkg::OFF_NCO_A: st_next.prdata = st_reg.nco_a;
        ddc_pkg::OFF_NCO_B: st_next.prdata = st_reg.nco_b;
        ddc_pkg::OFF_RESTART: st_next.prdata = 32'(st_reg.restart_bit);
        ddc_pkg::OFF_STATUS: begin
          st_next.prdata = '0;
          st_next.prdata[ddc_pkg::ST_PEND_A] = st_reg.pend_a;
          st_next.prdata[ddc_pkg::ST_PEND_B] = st_reg.pend_b;
          st_next.prdata[ddc_pkg::ST_SYNC_LSB +: ddc_pkg::SYNC_CNT_W] = st_reg.sync_cnt;
        end
        ddc_pkg::OFF_ACT_A: st_next.prdata = act_a;
        ddc_pkg::OFF_ACT_B: st_next.prdata = act_b;
        default: st_next.prdata = '0;
      endcase
    end

    // a toggle of the restart bit or a rising pin edge (pin enable set) is one sync event
    st_next.sync_pulse = pin_rise;
    if (wr && paddr == ddc_pkg::OFF_RESTART) begin
      st_next.restart_bit = pwdata[ddc_pkg::RESTART_BIT];
      if (pwdata[ddc_pkg::RESTART_BIT] != st_reg.restart_bit) begin
        st_next.sync_pulse = 1'b1;
      end
    end
    if (st_reg.sync_pulse) begin
      st_next.pend_a = 1'b0;
      st_next.pend_b = 1'b0;
    end
    // free divider phase lets software space resyncs by 64 cycles
    st_next.sync_cnt = st_reg.sync_pulse ? '0 : st_reg.sync_cnt + 6'h01;
    if (wr && paddr == ddc_pkg::OFF_CTRL) begin
      st_next.ctrl = pwdata;
    end
    if (wr && paddr == ddc_pkg::OFF_NCO_A) begin
      st_next.nco_a = pwdata;
      st_next.pend_a = 1'b1;
    end
    if (wr && paddr == ddc_pkg::OFF_NCO_B) begin
      st_next.nco_b = pwdata;
      st_next.pend_b = 1'b1;
    end

    // first lane pair
    st_next.o_valid = 1'b0;
    if (!en) begin
      st_next.o_valid = 1'b1;
      st_next.o_i = raw;
      st_next.o_q = '0;
      st_next.fs4_pend = 1'b0;
      st_next.fs4_odd = 1'b0;
    end else if (st_reg.ctrl[ddc_pkg::CTRL_FS4] && !real_mode) begin
      // sequence I, -Q, -I, Q: two real samples per complex one
      st_next.o_q = '0;
      if (dec_a.valid) begin
        st_next.o_valid = 1'b1;
        st_next.o_i = gain(dec_a.i, g6, g3, st_reg.fs4_odd);
        st_next.fs4_hold = gain(dec_a.q, g6, g3, ~st_reg.fs4_odd);
        st_next.fs4_pend = 1'b1;
        st_next.fs4_odd = ~st_reg.fs4_odd;
      end else if (st_reg.fs4_pend) begin
        st_next.o_valid = 1'b1;
        st_next.o_i = st_reg.fs4_hold;
        st_next.fs4_pend = 1'b0;
      end
    end else if (dec_a.valid) begin
      st_next.o_valid = 1'b1;
      st_next.o_i = gain(dec_a.i, g6, g3, 1'b0);
      st_next.o_q = real_mode ? '0 : gain(dec_a.q, g6, g3, 1'b0);
    end

    // second lane pair carries the oscillator b channel of the same converter, in dual mode only
    st_next.b_valid = en & dual & dec_b.valid;
    if (dec_b.valid) begin
      st_next.b_i = gain(dec_b.i, g6, g3, 1'b0);
      st_next.b_q = real_mode ? '0 : gain(dec_b.q, g6, g3, 1'b0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl <= ddc_pkg::CTRL_RST;
      st_reg.nco_a <= ddc_pkg::NCO_RST;
      st_reg.nco_b <= ddc_pkg::NCO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign out_valid = st_reg.o_valid;
  assign out_i = st_reg.o_i;
  assign out_q = st_reg.o_q;
  assign second_lane_pair_valid = st_reg.b_valid;
  assign second_lane_pair_i = st_reg.b_i;
  assign second_lane_pair_q = st_reg.b_q;
endmodule : ddc_top
`default_nettype wire

// ---- sim/ddc_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddc_top_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // streams
  input wire logic powerdown_or_align_pin,
  input wire logic out_valid,
  input wire logic [ddc_pkg::DATA_W-1:0] out_i,
  input wire logic [ddc_pkg::DATA_W-1:0] out_q,
  input wire logic second_lane_pair_valid
);
  logic [7:0] age;
  logic [5:0] gap;
  logic [31:0] ctrl;
  logic pin_d;
  wire logic wr = psel && penable && pready && pwrite;
  // settled: no write or pin change for a while, so dividers run steady
  wire logic calm = age >= 8'd80;
  wire logic ok = calm && ctrl[ddc_pkg::CTRL_EN];
  wire logic fs4 = ctrl[ddc_pkg::CTRL_FS4];
  wire logic [2:0] l2 = ctrl[10:8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= 8'h00;
      gap <= 6'h00;
      ctrl <= ddc_pkg::CTRL_RST;
      pin_d <= 1'b0;
    end else begin
      pin_d <= powerdown_or_align_pin;
      if (wr || pin_d != powerdown_or_align_pin) age <= 8'h00;
      else if (age != 8'hFF) age <= age + 8'h01;
      gap <= out_valid ? 6'h00 : gap + 6'h01;
      if (wr && paddr == ddc_pkg::OFF_CTRL) ctrl <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  a_bypass_every: assert property (calm && !ctrl[0] |-> out_valid && out_q == 20'h0 && out_i[5:0] == 6'h0)
    else $error("bypass stream wrong");
  a_second_idle: assert property (calm && !(ctrl[0] && ctrl[6]) |-> !second_lane_pair_valid)
    else $error("second lane active while off");
  a_strobe_gap: assert property (ok && !fs4 && out_valid |-> gap == (6'h01 << l2) - 6'h01)
    else $error("strobe spacing wrong");
  a_fs4_pair: assert property (ok && fs4 && l2 > 3'h1 && $rose(out_valid) |-> ##1 out_valid ##1 !out_valid)
    else $error("real pair not consecutive");
  a_fs4_qzero: assert property (ok && fs4 && out_valid |-> out_q == 20'h0)
    else $error("quarter mix q not zero");
  c_fs4: cover property (ok && fs4 && out_valid);
  c_err: cover property (pslverr);
  c_second: cover property (second_lane_pair_valid);
endmodule : ddc_top_chk
`default_nettype wire

// ---- sim/ddc_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddc_capture (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lane pairs
  input wire logic a_valid,
  input wire logic b_valid,
  // capture counts
  output logic [15:0] cnt_a,
  output logic [15:0] cnt_b
);
  // one word taken per strobe, nothing between strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
    end else begin
      if (a_valid) cnt_a <= cnt_a + 16'h0001;
      if (b_valid) cnt_b <= cnt_b + 16'h0001;
    end
  end
endmodule : ddc_capture
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [13:0] adc_sample = 14'h0000;
  logic align = 1'b0;
  logic ramp = 1'b1;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, a_v, b_v;
  wire logic [19:0] a_i, a_q, b_i, b_q;
  wire logic [15:0] cnt_a, cnt_b;
  logic [31:0] rd;
  logic er;
  logic [19:0] p;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) adc_sample <= ramp ? adc_sample + 14'h0001 : 14'h0100;
  ddc_top u_ddc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adc_sample, .powerdown_or_align_pin(align),
    .out_valid(a_v), .out_i(a_i), .out_q(a_q), .second_lane_pair_valid(b_v),
    .second_lane_pair_i(b_i), .second_lane_pair_q(b_q));
  ddc_capture u_ddc_capture (.pclk, .presetn, .a_valid(a_v), .b_valid(b_v),
    .cnt_a, .cnt_b);
  task summarize;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge; holds the request until pready
  // waits with no limit of its own: only the cycle ceiling ends a hang
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next call never drives psel twice in one step
    @(posedge pclk);
  endtask : xfer
  task rate(input logic [31:0] c, input int ea, input int eb);
    logic [15:0] a0, b0;
    xfer(1'b1, ddc_pkg::OFF_CTRL, c);
    repeat (100) @(posedge pclk);
    a0 = cnt_a;
    b0 = cnt_b;
    // window is a multiple of every ratio, so counts are exact
    repeat (128) @(posedge pclk);
    chk(32'(cnt_a - a0), 32'(ea));
    chk(32'(cnt_b - b0), 32'(eb));
  endtask : rate
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, ddc_pkg::OFF_CTRL, 32'h0);
    chk(rd, ddc_pkg::CTRL_RST);
    xfer(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    repeat (4) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      p = a_i;
      @(posedge pclk);
      chk({12'h0, 20'(a_i - p)}, 32'h40);
      chk({12'h0, a_q}, 32'h0);
    end
    $display("test bypass done");
    for (int l = 1; l <= 5; l++) rate(32'(32'h41 | (l << 8)), 128 >> l, 128 >> l);
    rate(32'h343, 16, 16);
    rate(32'h311, 32, 0);
    $display("test rates done");
    // minus an eighth of the sample rate: the rate stays pending and takes effect only at the next sync event
    xfer(1'b1, ddc_pkg::OFF_NCO_A, 32'hE000_0000);
    xfer(1'b0, ddc_pkg::OFF_ACT_A, 32'h0);
    chk(rd, ddc_pkg::NCO_RST);
    xfer(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    xfer(1'b1, ddc_pkg::OFF_RESTART, 32'h1);
    repeat (2) @(posedge pclk);
    xfer(1'b0, ddc_pkg::OFF_ACT_A, 32'h0);
    chk(rd, 32'hE000_0000);
    xfer(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    p = rd[19:0];
    repeat (61) @(posedge pclk);
    xfer(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk({26'h0, rd[13:8]}, {26'h0, p[13:8]});
    xfer(1'b1, ddc_pkg::OFF_NCO_B, 32'h2468_ACE0);
    xfer(1'b1, ddc_pkg::OFF_CTRL, 32'h941);
    align <= 1'b1;
    repeat (8) @(posedge pclk);
    xfer(1'b0, ddc_pkg::OFF_ACT_B, 32'h0);
    chk(rd, 32'h2468_ACE0);
    align <= 1'b0;
    $display("test sync done");
    ramp <= 1'b0;
    // constant input through the real path: gains are exact ratios
    xfer(1'b1, ddc_pkg::OFF_CTRL, 32'h143);
    repeat (100) @(posedge pclk);
    chk({12'h0, a_i}, 32'h4000);
    chk({12'h0, a_q}, 32'h0);
    chk({12'h0, b_i}, 32'h4000);
    chk({12'h0, b_q}, 32'h0);
    xfer(1'b1, ddc_pkg::OFF_CTRL, 32'h107);
    repeat (100) @(posedge pclk);
    chk({12'h0, a_i}, 32'h8000);
    xfer(1'b1, ddc_pkg::OFF_CTRL, 32'h10B);
    repeat (100) @(posedge pclk);
    chk({12'h0, a_i}, 32'h5A00);
    $display("test gain done");
    // oscillator held at zero phase: inverting the phase must negate q
    xfer(1'b1, ddc_pkg::OFF_NCO_A, 32'h0);
    xfer(1'b1, ddc_pkg::OFF_RESTART, 32'h0);
    xfer(1'b1, ddc_pkg::OFF_CTRL, 32'h101);
    repeat (100) @(posedge pclk);
    p = a_q;
    chk({31'h0, p == 20'h0}, 32'h0);
    xfer(1'b1, ddc_pkg::OFF_CTRL, 32'h121);
    repeat (100) @(posedge pclk);
    chk({12'h0, 20'(a_q + p)}, 32'h0);
    $display("test mixer done");
    summarize();
  end
endmodule : testbench
bind ddc_top ddc_top_chk u_ddc_top_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .powerdown_or_align_pin, .out_valid,
  .out_i, .out_q, .second_lane_pair_valid);
`default_nettype wire
